// ### core/osd_pkg.sv
/*
  constants for the character overlay: register offsets, field positions,
  reset values and geometry figures.
  assumes 12-bit register data and a 9-bit word address, the upper half of
  which is the memory page.
*/
package osd_pkg;
  // memory layout
  localparam int unsigned SRAM_WORDS   = 1536;
  localparam logic [11:0] SRAM_TOP     = 12'h600;
  // register offsets, colour map takes 8'h00 to 8'h0f
  localparam logic [3:0]  REG_CMAP_HI  = 4'h0;
  localparam logic [7:0]  REG_CTRL     = 8'h10;
  localparam logic [7:0]  REG_CODE_BASE = 8'h11;
  localparam logic [7:0]  REG_CELL_W   = 8'h12;
  localparam logic [7:0]  REG_CELL_H   = 8'h13;
  localparam logic [7:0]  REG_OFS_X    = 8'h14;
  localparam logic [7:0]  REG_OFS_Y    = 8'h15;
  localparam logic [7:0]  REG_WIN_COLS = 8'h16;
  localparam logic [7:0]  REG_WIN_ROWS = 8'h17;
  localparam logic [7:0]  REG_START_X  = 8'h18;
  localparam logic [7:0]  REG_START_Y  = 8'h19;
  localparam logic [7:0]  REG_BORDER_IDX = 8'h1a;
  localparam logic [7:0]  REG_SEGMENT  = 8'h1b;
  localparam logic [7:0]  REG_STATUS   = 8'h1c;
  // control register fields
  localparam int unsigned CTRL_EN       = 0;
  localparam int unsigned CTRL_PORTRAIT = 1;
  localparam int unsigned CTRL_BORDER   = 2;
  localparam int unsigned CTRL_SHADOW   = 3;
  localparam int unsigned CTRL_BW_LO    = 4;
  localparam int unsigned CTRL_BLINK64  = 6;
  localparam int unsigned CTRL_DUTY_LO  = 7;
  // reset values
  localparam logic [5:0]  CELL_W_RST   = 6'h07;
  localparam logic [5:0]  CELL_H_RST   = 6'h10;
  localparam logic [3:0]  BORDER_IDX_RST = 4'hf;
  // character code fields
  localparam int unsigned CODE_BG_LO   = 7;
  localparam int unsigned CODE_FG_LO   = 9;
  localparam int unsigned CODE_BLINK   = 11;
  localparam logic [1:0]  BG_TRANSPARENT = 2'h3;
  // colour map entries used
  localparam logic [3:0]  FG_BASE      = 4'h4;
  // geometry
  localparam logic [6:0]  CELL_W_MIN   = 7'h05;
  localparam logic [6:0]  CELL_H_MIN   = 7'h02;
  localparam logic [6:0]  GLYPH_W      = 7'h0c;
  localparam logic [6:0]  GLYPH_H_PORTRAIT = 7'h0c;
  localparam logic [6:0]  GLYPH_H_LANDSCAPE = 7'h12;
  localparam logic [3:0]  GLYPH_MSB    = 4'hb;
  localparam logic [14:0] SHADOW_OFS   = 15'h0008;
  // blink duty codes
  localparam logic [1:0]  DUTY_25      = 2'h0;
  localparam logic [1:0]  DUTY_75      = 2'h2;
endpackage

// ### core/osd_blink_if.sv
/*
  link between the overlay and its blink phase generator.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface osd_blink_if;
  logic       frame_start;
  logic       period64;
  logic [1:0] duty;
  logic       blink_on;
  logic [5:0] phase;
  modport gen  (input frame_start, period64, duty, output blink_on, phase);
  modport user (output frame_start, period64, duty, input blink_on, phase);
endinterface

// ### core/osd_blink_gen.sv
/*
  blink phase generator: frame counter and on/off decision.
  assumes frame_start is a one-cycle pulse on core_clk.
*/
`timescale 1ns/1ps
module osd_blink_gen (
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   rstn,
  input  wire logic   ce,
  // overlay side
  osd_blink_if.gen    bl
);
  typedef struct packed {
    logic [5:0] cnt;
    logic       on;
  } osd_blink_state_t;

  osd_blink_state_t s_q;
  osd_blink_state_t s_d;
  logic [2:0]       quarters;

  always_comb begin
    s_d = s_q;
    quarters = 3'h2;
    if (bl.duty == osd_pkg::DUTY_25) begin
      quarters = 3'h1;
    end else if (bl.duty == osd_pkg::DUTY_75) begin
      quarters = 3'h3;
    end
    if (bl.frame_start) begin
      s_d.cnt = s_q.cnt + 6'h01;
    end
    if (bl.period64) begin
      s_d.on = {1'b0, s_d.cnt} < {quarters, 4'h0};
    end else begin
      s_d.on = {1'b0, s_d.cnt[4:0]} < {quarters, 3'h0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign bl.blink_on = s_q.on;
  assign bl.phase    = s_q.cnt;
endmodule

// ### core/osd_colour_expand.sv
/*
  widens a colour map entry of three 4-bit components to 8-bit components.
  assumes blue in the low nibble, red in the high nibble.
*/
`timescale 1ns/1ps
module osd_colour_expand #(
  parameter int unsigned COMPONENTS = 3
) (
  // colour map entry in, full colour out
  input  wire logic [4*COMPONENTS-1:0] entry,
  output wire logic [8*COMPONENTS-1:0] rgb
);
  if (COMPONENTS < 1) begin : g_bad
    $error("osd_colour_expand needs at least one component");
  end

  for (genvar i = 0; i < COMPONENTS; i++) begin : g_comp
    assign rgb[8*i+:8] = {entry[4*i+:4], {4{|entry[4*i+:4]}}};
  end
endmodule

// ### core/osd_character_overlay.sv
/*
  character overlay: register file, font and code memory, window geometry,
  two-stage pixel pipeline with border, shadow and blink.
  assumes panel inputs and the font rom answer on core_clk; rom_data is
  valid in the same cycle as rom_addr.
*/
`timescale 1ns/1ps
// What this block does
// - portrait fonts come only from sram, glyph 12 pixels by 12 lines.
// - code start address is an 8-bit value times 16.
// - code bits 6..0 are the top seven bits of the glyph line address.
// - code bits 8..7 pick background 0, 1, 2, or transparent for 11.
// - code bits 10..9 pick one of four foreground colours.
// - code bit 11 set makes the character blink.
// - seven colour entries used by characters, background indexes 0 to 2 directly, foreground adds FG_BASE for 4 to 7.
// - blink period 32 or 64 frames, duty 25, 50 or 75 percent.
// - host page shows one of six 256-word memory segments.
// - cell width 5 to 68 pixels, height 2 to 65 lines.
// - glyph offset inside the cell 0 to 63 each way.
// - window 1 to 64 characters wide and rows high.
// - window start 0 to 2047 in panel pixels and lines.
// - optional solid border 1, 2, 4 or 8 wide from colour map.
// - font line bit 11 is the leftmost pixel.
// - coordinates count from display enable leading edges.
// - start position includes the border; characters start inside it.
// - shadow halves video over window area moved 8 right, 8 down.
// - colours cover shadow, transparent shows halved video, panel background untouched.
// - window size does not depend on video scaling.
// - colour entry is red, green, blue nibbles high to low.
// - widened component low nibble is all ones if any high bit set.
// - window may appear anywhere display enable is active.
module osd_character_overlay (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // register port
  input  wire logic [8:0]  reg_addr,
  input  wire logic [11:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [11:0] reg_rdata,
  // font rom
  output logic      [9:0]  rom_addr,
  input  wire logic [11:0] rom_data,
  // panel video in
  input  wire logic        panel_hde,
  input  wire logic        panel_vde,
  input  wire logic        panel_bg,
  input  wire logic [23:0] video_rgb,
  // panel video out
  output logic      [23:0] out_rgb,
  output logic             out_de,
  output logic             out_vde
);
  typedef struct packed {
    logic [15:0][11:0] cmap;
    logic [11:0] ctrl;
    logic [7:0]  code_base;
    logic [5:0]  cell_w;
    logic [5:0]  cell_h;
    logic [5:0]  ofs_x;
    logic [5:0]  ofs_y;
    logic [5:0]  cols_m1;
    logic [5:0]  rows_m1;
    logic [10:0] start_x;
    logic [10:0] start_y;
    logic [3:0]  border_idx;
    logic [3:0]  segment;
    logic [11:0] rdata;
    logic        hde_d;
    logic        vde_d;
    logic [11:0] h;
    logic [11:0] v;
    logic [6:0]  cx;
    logic [5:0]  col;
    logic        hact;
    logic [6:0]  cy;
    logic [5:0]  row;
    logic        vact;
    logic        s1_de;
    logic        s1_vde;
    logic        s1_bg;
    logic [23:0] s1_video;
    logic        s1_char;
    logic        s1_glyph;
    logic        s1_win;
    logic        s1_shadow;
    logic [11:0] s1_code;
    logic [3:0]  s1_gx;
    logic        s1_rom;
    logic [9:0]  rom_addr;
    logic [11:0] font;
    logic [23:0] out_rgb;
    logic        out_de;
    logic        out_vde;
  } osd_state_t;

  osd_state_t  s_q;
  osd_state_t  s_d;
  logic [11:0] sram_mem [0:osd_pkg::SRAM_WORDS-1];

  logic        en;
  logic        portrait;
  logic        border_en;
  logic        shadow_en;
  logic [3:0]  bsz;
  logic [6:0]  cellw;
  logic [6:0]  cellh;
  logic [6:0]  cols;
  logic [6:0]  rows;
  logic [13:0] winw;
  logic [13:0] winh;
  logic [14:0] h15;
  logic [14:0] v15;
  logic [14:0] sx15;
  logic [14:0] sy15;
  logic [14:0] b15;
  logic [14:0] xe15;
  logic [14:0] ye15;
  logic        win_h;
  logic        win_v;
  logic        shad_h;
  logic        shad_v;
  logic        hhit;
  logic        vhit;
  logic        hin;
  logic        vin;
  logic [6:0]  ccx;
  logic [5:0]  ccol;
  logic [6:0]  ccy;
  logic [5:0]  crow;
  logic [6:0]  gx;
  logic [6:0]  gy;
  logic [6:0]  gh;
  logic        gx_ok;
  logic        gy_ok;
  logic [11:0] ca;
  logic [11:0] code_word;
  logic [11:0] fa;
  logic [11:0] fa_rom;
  logic [11:0] mem_idx;
  logic [11:0] font_word;
  logic        font_bit;
  logic        fg_on;
  logic [1:0]  bg_sel;
  logic [23:0] half_rgb;
  logic [23:0] vid_rgb;
  logic        use_map;
  logic [3:0]  map_idx;
  logic [23:0] map_rgb;
  logic [11:0] reg_val;

  osd_blink_if blink_bus ();

  assign blink_bus.frame_start = panel_vde & ~s_q.vde_d;
  assign blink_bus.period64    = s_q.ctrl[osd_pkg::CTRL_BLINK64];
  assign blink_bus.duty        = s_q.ctrl[osd_pkg::CTRL_DUTY_LO+:2];

  osd_blink_gen u_blink (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ce       (ce),
    .bl       (blink_bus.gen)
  );

  osd_colour_expand #(
    .COMPONENTS (3)
  ) u_expand (
    .entry (s_q.cmap[map_idx]),
    .rgb   (map_rgb)
  );

  assign en        = s_q.ctrl[osd_pkg::CTRL_EN];
  assign portrait  = s_q.ctrl[osd_pkg::CTRL_PORTRAIT];
  assign border_en = s_q.ctrl[osd_pkg::CTRL_BORDER];
  assign shadow_en = s_q.ctrl[osd_pkg::CTRL_SHADOW];
  // border width 1, 2, 4 or 8
  assign bsz       = border_en ? (4'h1 << s_q.ctrl[osd_pkg::CTRL_BW_LO+:2]) : 4'h0;
  assign cellw     = {1'b0, s_q.cell_w} + osd_pkg::CELL_W_MIN;
  assign cellh     = {1'b0, s_q.cell_h} + osd_pkg::CELL_H_MIN;
  assign cols      = {1'b0, s_q.cols_m1} + 7'h01;
  assign rows      = {1'b0, s_q.rows_m1} + 7'h01;
  assign winw      = {7'h00, cols} * {7'h00, cellw};
  assign winh      = {7'h00, rows} * {7'h00, cellh};

  assign h15  = {3'h0, s_q.h};
  assign v15  = {3'h0, s_q.v};
  assign sx15 = {4'h0, s_q.start_x};
  assign sy15 = {4'h0, s_q.start_y};
  assign b15  = {11'h000, bsz};
  assign xe15 = sx15 + {1'b0, winw} + b15 + b15;
  assign ye15 = sy15 + {1'b0, winh} + b15 + b15;
  assign win_h  = panel_hde && h15 >= sx15 && h15 < xe15;
  assign win_v  = panel_vde && v15 >= sy15 && v15 < ye15;
  assign shad_h = panel_hde && h15 >= sx15 + osd_pkg::SHADOW_OFS && h15 < xe15 + osd_pkg::SHADOW_OFS;
  assign shad_v = panel_vde && v15 >= sy15 + osd_pkg::SHADOW_OFS && v15 < ye15 + osd_pkg::SHADOW_OFS;

  assign vhit = panel_vde && v15 == sy15 + b15;
  assign vin  = vhit | s_q.vact;
  assign ccy  = vhit ? 7'h00 : s_q.cy;
  assign crow = vhit ? 6'h00 : s_q.row;
  assign hhit = panel_hde && vin && h15 == sx15 + b15;
  assign hin  = hhit | s_q.hact;
  assign ccx  = hhit ? 7'h00 : s_q.cx;
  assign ccol = hhit ? 6'h00 : s_q.col;

  assign gx    = ccx - {1'b0, s_q.ofs_x};
  assign gy    = ccy - {1'b0, s_q.ofs_y};
  assign gh    = portrait ? osd_pkg::GLYPH_H_PORTRAIT : osd_pkg::GLYPH_H_LANDSCAPE;
  assign gx_ok = ccx >= {1'b0, s_q.ofs_x} && gx < osd_pkg::GLYPH_W;
  assign gy_ok = ccy >= {1'b0, s_q.ofs_y} && gy < gh;

  // code base in steps of 16
  assign ca        = {s_q.code_base, 4'h0} + ({6'h00, crow} * {5'h00, cols}) + {6'h00, ccol};
  assign code_word = (ca < osd_pkg::SRAM_TOP) ? sram_mem[ca[10:0]] : 12'h000;
  // font select forms top address bits
  assign fa        = {code_word[6:0], 5'h00} + {7'h00, gy[4:0]};
  assign fa_rom    = fa - osd_pkg::SRAM_TOP;
  assign mem_idx   = {s_q.segment, reg_addr[7:0]};

  assign font_word = s_q.s1_rom ? rom_data : s_q.font;
  assign font_bit  = font_word[osd_pkg::GLYPH_MSB - s_q.s1_gx];
  assign fg_on     = s_q.s1_glyph && font_bit &&
                     !(s_q.s1_code[osd_pkg::CODE_BLINK] && !blink_bus.blink_on);
  assign bg_sel    = s_q.s1_code[osd_pkg::CODE_BG_LO+:2];
  assign half_rgb  = {1'b0, s_q.s1_video[23:17], 1'b0, s_q.s1_video[15:9], 1'b0, s_q.s1_video[7:1]};
  assign vid_rgb   = (en && shadow_en && s_q.s1_shadow && !s_q.s1_bg) ? half_rgb : s_q.s1_video;

  always_comb begin
    use_map = 1'b0;
    map_idx = 4'h0;
    if (en && s_q.s1_char) begin
      if (fg_on) begin
        use_map = 1'b1;
        map_idx = osd_pkg::FG_BASE + {2'h0, s_q.s1_code[osd_pkg::CODE_FG_LO+:2]};
      end else if (bg_sel != osd_pkg::BG_TRANSPARENT) begin
        use_map = 1'b1;
        map_idx = {2'h0, bg_sel};
      end
    end else if (en && border_en && s_q.s1_win) begin
      use_map = 1'b1;
      map_idx = s_q.border_idx;
    end
  end

  always_comb begin
    reg_val = 12'h000;
    if (reg_addr[8]) begin
      if (mem_idx < osd_pkg::SRAM_TOP) begin
        reg_val = sram_mem[mem_idx[10:0]];
      end
    end else if (reg_addr[7:4] == osd_pkg::REG_CMAP_HI) begin
      reg_val = s_q.cmap[reg_addr[3:0]];
    end else begin
      case (reg_addr[7:0])
        osd_pkg::REG_CTRL:       reg_val = s_q.ctrl;
        osd_pkg::REG_CODE_BASE:  reg_val = {4'h0, s_q.code_base};
        osd_pkg::REG_CELL_W:     reg_val = {6'h00, s_q.cell_w};
        osd_pkg::REG_CELL_H:     reg_val = {6'h00, s_q.cell_h};
        osd_pkg::REG_OFS_X:      reg_val = {6'h00, s_q.ofs_x};
        osd_pkg::REG_OFS_Y:      reg_val = {6'h00, s_q.ofs_y};
        osd_pkg::REG_WIN_COLS:   reg_val = {6'h00, s_q.cols_m1};
        osd_pkg::REG_WIN_ROWS:   reg_val = {6'h00, s_q.rows_m1};
        osd_pkg::REG_START_X:    reg_val = {1'b0, s_q.start_x};
        osd_pkg::REG_START_Y:    reg_val = {1'b0, s_q.start_y};
        osd_pkg::REG_BORDER_IDX: reg_val = {8'h00, s_q.border_idx};
        osd_pkg::REG_SEGMENT:    reg_val = {8'h00, s_q.segment};
        osd_pkg::REG_STATUS:     reg_val = {4'h0, s_q.vact, blink_bus.blink_on, blink_bus.phase};
        default:                 reg_val = 12'h000;
      endcase
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = reg_rd ? reg_val : 12'h000;
    if (reg_wr && !reg_addr[8]) begin
      if (reg_addr[7:4] == osd_pkg::REG_CMAP_HI) begin
        s_d.cmap[reg_addr[3:0]] = reg_wdata;
      end else begin
        case (reg_addr[7:0])
          osd_pkg::REG_CTRL:       s_d.ctrl       = {3'h0, reg_wdata[8:0]};
          osd_pkg::REG_CODE_BASE:  s_d.code_base  = reg_wdata[7:0];
          osd_pkg::REG_CELL_W:     s_d.cell_w     = reg_wdata[5:0];
          osd_pkg::REG_CELL_H:     s_d.cell_h     = reg_wdata[5:0];
          osd_pkg::REG_OFS_X:      s_d.ofs_x      = reg_wdata[5:0];
          osd_pkg::REG_OFS_Y:      s_d.ofs_y      = reg_wdata[5:0];
          osd_pkg::REG_WIN_COLS:   s_d.cols_m1    = reg_wdata[5:0];
          osd_pkg::REG_WIN_ROWS:   s_d.rows_m1    = reg_wdata[5:0];
          osd_pkg::REG_START_X:    s_d.start_x    = reg_wdata[10:0];
          osd_pkg::REG_START_Y:    s_d.start_y    = reg_wdata[10:0];
          osd_pkg::REG_BORDER_IDX: s_d.border_idx = reg_wdata[3:0];
          osd_pkg::REG_SEGMENT:    s_d.segment    = reg_wdata[3:0];
          default:                 s_d.segment    = s_q.segment;
        endcase
      end
    end

    // panel position counters
    s_d.hde_d = panel_hde;
    s_d.vde_d = panel_vde;
    s_d.h     = panel_hde ? s_q.h + 12'h001 : 12'h000;
    if (!panel_vde) begin
      s_d.v = 12'h000;
    end else if (s_q.hde_d && !panel_hde) begin
      s_d.v = s_q.v + 12'h001;
    end

    // cell walk across a line
    if (!panel_hde) begin
      s_d.hact = 1'b0;
    end else if (hin) begin
      s_d.hact = 1'b1;
      s_d.col  = ccol;
      s_d.cx   = ccx + 7'h01;
      if (ccx == cellw - 7'h01) begin
        s_d.cx  = 7'h00;
        s_d.col = ccol + 6'h01;
        if (ccol == s_q.cols_m1) begin
          s_d.hact = 1'b0;
        end
      end
    end

    // row walk down the frame, stepped at line end
    if (!panel_vde) begin
      s_d.vact = 1'b0;
    end else if (s_q.hde_d && !panel_hde && vin) begin
      s_d.vact = 1'b1;
      s_d.row  = crow;
      s_d.cy   = ccy + 7'h01;
      if (ccy == cellh - 7'h01) begin
        s_d.cy  = 7'h00;
        s_d.row = crow + 6'h01;
        if (crow == s_q.rows_m1) begin
          s_d.vact = 1'b0;
        end
      end
    end

    // stage one: code and font fetch
    s_d.s1_de     = panel_hde;
    s_d.s1_vde    = panel_vde;
    s_d.s1_bg     = panel_bg;
    s_d.s1_video  = video_rgb;
    s_d.s1_char   = panel_hde && hin && vin;
    s_d.s1_glyph  = panel_hde && hin && vin && gx_ok && gy_ok;
    s_d.s1_win    = win_h && win_v;
    s_d.s1_shadow = shad_h && shad_v;
    s_d.s1_code   = code_word;
    s_d.s1_gx     = gx[3:0];
    s_d.s1_rom    = !portrait && fa >= osd_pkg::SRAM_TOP;
    s_d.rom_addr  = fa_rom[9:0];
    s_d.font      = (fa < osd_pkg::SRAM_TOP) ? sram_mem[fa[10:0]] : 12'h000;

    // stage two: pixel out
    s_d.out_de  = s_q.s1_de;
    s_d.out_vde = s_q.s1_vde;
    if (!s_q.s1_de) begin
      s_d.out_rgb = 24'h000000;
    end else if (use_map) begin
      s_d.out_rgb = map_rgb;
    end else begin
      s_d.out_rgb = vid_rgb;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s_q            <= '0;
      s_q.cell_w     <= osd_pkg::CELL_W_RST;
      s_q.cell_h     <= osd_pkg::CELL_H_RST;
      s_q.border_idx <= osd_pkg::BORDER_IDX_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rstn && ce && reg_wr && reg_addr[8] && mem_idx < osd_pkg::SRAM_TOP) begin
      sram_mem[mem_idx[10:0]] <= reg_wdata;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign rom_addr  = s_q.rom_addr;
  assign out_rgb   = s_q.out_rgb;
  assign out_de    = s_q.out_de;
  assign out_vde   = s_q.out_vde;
endmodule

// ### dv/osd_rom_model.sv
/*
  font rom stand-in: answers in the cycle in which the address stands,
  with a word that changes with every address.
  assumes the overlay takes rom_data at the edge after it sets rom_addr.
*/
`timescale 1ns/1ps
module osd_rom_model (
  // rom port
  input  wire logic [9:0]  rom_addr,
  output logic      [11:0] rom_data
);
  // pattern, so a stale or wrong fetch looks like a blank line only at rom_addr 10'h25a
  always_comb begin
    rom_data = {rom_addr[1:0], rom_addr} ^ 12'ha5a;
  end
endmodule

// ### dv/osd_character_overlay_chk.sv
/*
  port checker for the character overlay.
  assumes one clock domain and the overlay's own register map.
*/
`timescale 1ns/1ps
module osd_character_overlay_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        ce,
  // register port
  input wire logic [8:0]  reg_addr,
  input wire logic [11:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_rdata,
  // panel
  input wire logic        panel_hde,
  input wire logic        panel_vde,
  input wire logic [23:0] out_rgb,
  input wire logic        out_de,
  input wire logic        out_vde
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_de_lat;
    $past(rstn, 2) && $past(rstn) && $past(ce) && $past(ce, 2) |-> out_de == $past(panel_hde, 2);
  endproperty
  a_de_lat: assert property (p_de_lat) else $error("out_de lag wrong");
  property p_vde_lat;
    $past(rstn, 2) && $past(rstn) && $past(ce) && $past(ce, 2) |-> out_vde == $past(panel_vde, 2);
  endproperty
  a_vde_lat: assert property (p_vde_lat) else $error("out_vde lag wrong");
  property p_blank;
    !out_de |-> out_rgb == 24'h000000;
  endproperty
  a_blank: assert property (p_blank) else $error("colour outside enable");
  property p_rd_idle;
    ce && !reg_rd |=> reg_rdata == 12'h000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_unmapped;
    reg_rd && ce && !reg_addr[8] && reg_addr[7:0] > 8'h1c |=> reg_rdata == 12'h000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_status_hi;
    reg_rd && ce && reg_addr == 9'h01c |=> reg_rdata[11:8] == 4'h0;
  endproperty
  a_status_hi: assert property (p_status_hi) else $error("status upper bits set");
  property p_ctrl_wb;
    reg_wr && ce && reg_addr == 9'h010 ##1 !reg_wr ##1 reg_rd && ce && reg_addr == 9'h010
      |=> reg_rdata == ($past(reg_wdata, 3) & 12'h1ff);
  endproperty
  a_ctrl_wb: assert property (p_ctrl_wb) else $error("control readback wrong");
  property p_startx_wb;
    reg_wr && ce && reg_addr == 9'h018 ##1 !reg_wr ##1 reg_rd && ce && reg_addr == 9'h018
      |=> reg_rdata == ($past(reg_wdata, 3) & 12'h7ff);
  endproperty
  a_startx_wb: assert property (p_startx_wb) else $error("start x readback wrong");
  property p_cellw_wb;
    reg_wr && ce && reg_addr == 9'h012 ##1 !reg_wr ##1 reg_rd && ce && reg_addr == 9'h012
      |=> reg_rdata == ($past(reg_wdata, 3) & 12'h03f);
  endproperty
  a_cellw_wb: assert property (p_cellw_wb) else $error("cell width readback wrong");
endmodule
bind osd_character_overlay osd_character_overlay_chk u_chk (.core_clk(core_clk), .rstn(rstn), .ce(ce),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .panel_hde(panel_hde), .panel_vde(panel_vde), .out_rgb(out_rgb), .out_de(out_de), .out_vde(out_vde));

// ### dv/osd_character_overlay_tb.sv
/*
  testbench for the character overlay: register access, memory page,
  clock enable, and frames of one rendered and blinking character.
  assumes the rom model beside it and the overlay's register map.
*/
`timescale 1ns/1ps
module osd_character_overlay_tb;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic [8:0]  reg_addr = 9'h000;
  logic [11:0] reg_wdata = 12'h000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [11:0] reg_rdata, rom_data, rd_val;
  logic [9:0]  rom_addr;
  logic        panel_hde = 1'b0;
  logic        panel_vde = 1'b0;
  logic        panel_bg = 1'b0;
  logic [23:0] video_rgb = 24'h808080;
  logic [23:0] out_rgb;
  logic        out_de, out_vde;
  logic [23:0] pix [0:15][0:31];
  int          ox, oy, num_errors, tests_run;
  logic [8:0]  ra [6] = '{9'h010, 9'h011, 9'h012, 9'h016, 9'h018, 9'h01a};
  logic [11:0] rv [6] = '{12'h000, 12'h000, 12'h007, 12'h000, 12'h000, 12'h00f};
  logic [11:0] mk [6] = '{12'h1ff, 12'h0ff, 12'h03f, 12'h03f, 12'h7ff, 12'h00f};
  logic [8:0]  sa [10] = '{9'h004, 9'h000, 9'h00f, 9'h011, 9'h012, 9'h013, 9'h016, 9'h018, 9'h01a, 9'h010};
  logic [11:0] sd [10] = '{12'hf0f, 12'h120, 12'h0a0, 12'h040, 12'h007, 12'h00a, 12'h000, 12'h004,
                           12'h00f, 12'h003};

  always #20 core_clk = ~core_clk;

  osd_character_overlay dut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rom_addr(rom_addr),
    .rom_data(rom_data), .panel_hde(panel_hde), .panel_vde(panel_vde), .panel_bg(panel_bg),
    .video_rgb(video_rgb), .out_rgb(out_rgb), .out_de(out_de), .out_vde(out_vde));
  osd_rom_model u_rom (.rom_addr(rom_addr), .rom_data(rom_data));

  // picture rebuilt from the delayed enables
  always @(posedge core_clk) begin
    if (!out_vde) begin
      oy <= 0;
      ox <= 0;
    end else if (out_de) begin
      pix[oy][ox] <= out_rgb;
      ox <= ox + 1;
    end else if (ox != 0) begin
      oy <= oy + 1;
      ox <= 0;
    end
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [11:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [11:0] exp, input logic [11:0] m = 12'hfff);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata & m;
    check({12'h000, rd_val}, {12'h000, exp});
  endtask

  // twelve lines of 32 pixels, panel background from pixel 20 on
  task automatic frame();
    @(posedge core_clk);
    panel_vde <= 1'b1;
    for (int l = 0; l < 12; l++) begin
      for (int x = 0; x < 32; x++) begin
        @(posedge core_clk);
        panel_hde <= 1'b1;
        panel_bg <= (x >= 20);
      end
      @(posedge core_clk);
      panel_hde <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    panel_vde <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], rv[i]);
      wr(ra[i], 12'hfff);
      rd(ra[i], mk[i]);
    end
    rd(9'h013, 12'h010);
    wr(9'h01d, 12'hfff);
    rd(9'h01d, 12'h000);
    rd(9'h0ff, 12'h000);
    wr(9'h01b, 12'h006);
    wr(9'h100, 12'h123);
    rd(9'h100, 12'h000);
    wr(9'h01b, 12'h004);
    wr(9'h100, 12'h001);
    rd(9'h100, 12'h001);
    wr(9'h01b, 12'h000);
    wr(9'h120, 12'h800);
    rd(9'h120, 12'h800);
    ce <= 1'b0;
    wr(9'h014, 12'h005);
    ce <= 1'b1;
    rd(9'h014, 12'h000);
    for (int i = 0; i < 10; i++) begin
      wr(sa[i], sd[i]);
    end
    frame();
    check(pix[0][3], 24'h808080);
    check(pix[0][4], 24'hff00ff);
    check(pix[0][5], 24'h1f2f00);
    wr(9'h010, 12'h00b);
    frame();
    check(pix[0][4], 24'hff00ff);
    check(pix[8][16], 24'h404040);
    check(pix[8][20], 24'h808080);
    check(pix[8][2], 24'h808080);
    wr(9'h010, 12'h007);
    frame();
    check(pix[0][4], 24'h00af00);
    check(pix[1][5], 24'hff00ff);
    check(pix[1][6], 24'h1f2f00);
    rd(9'h01c, 12'h003, 12'h03f);
    wr(9'h01b, 12'h004);
    wr(9'h100, 12'h801);
    wr(9'h010, 12'h003);
    repeat (5) frame();
    check(pix[0][4], 24'h1f2f00);
    rd(9'h01c, 12'h008, 12'h07f);
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    stop_test();
  end
endmodule
